// ---- inc/frp_pkg.sv ----
package frp_pkg;
    localparam int          FRP_DW        = 36;
    localparam int          FRP_BW        = 9;
    localparam int          FRP_WB_AW     = 8;
    // Register byte addresses
    localparam logic [7:0]  FRP_CTRL_ADR  = 8'h00;
    localparam logic [7:0]  FRP_STAT_ADR  = 8'h04;
    // Control fields
    localparam int          FRP_CTRL_ODD  = 0;
    localparam logic        FRP_CTRL_RST  = 1'h1;
    // Status fields
    localparam int          FRP_ST_PEA    = 0;
    localparam int          FRP_ST_PEB    = 1;
    localparam int          FRP_ST_SIZE   = 2;
    localparam int          FRP_ST_BE     = 4;
    localparam int          FRP_ST_PEND   = 5;
    localparam int          FRP_ST_IDX    = 6;
    localparam int          FRP_ST_SWAP   = 8;
    // Port B size codes, {hi, lo}
    localparam logic [1:0]  FRP_SZ_LONG   = 2'h0;
    localparam logic [1:0]  FRP_SZ_WORD   = 2'h1;
    localparam logic [1:0]  FRP_SZ_BYTE   = 2'h2;
    localparam logic [1:0]  FRP_SZ_MAIL   = 2'h3;
    localparam logic [1:0]  FRP_SZ_RST    = 2'h0;
    localparam logic        FRP_BE_RST    = 1'h0;
endpackage : frp_pkg

// ---- src/frp_read_path.sv ----
// Summary of operation
// [RULE1] Array always yields whole 36-bit words; long size loads all at once.
// [RULE2] Word/byte sizes output first part, keep rest in auxiliary register.
// [RULE3] Read with a changed size fetches fresh word, discarding unread parts.
// [RULE4] Output lanes outside the selected size keep their previous value.
// [RULE5] Swapping applies to FIFO data only, whole 9-bit bytes moved.
// [RULE6] Swap selects sampled on fetching edge, kept for the whole word.
// [RULE7] Swap codes: LL ABCD, LH DCBA, HL CDAB, HH BADC.
// [RULE8] Bytes are reordered first, then split into words or bytes.
// [RULE9] Both size selects high: B read gives A-to-B, write loads B-to-A.
// [RULE10] Mailbox access leaves unpacking and registered size untouched.
// [RULE11] Each edge uses registered size and endian selections.
// [RULE12] Port A checks four 9-bit bytes; any failure drives error low.
// [RULE13] Port B checks only bytes valid for the current size.
// [RULE14] Odd/even select decides whether odd or even low count fails.
// [RULE15] Port A mailbox read with generation forces its error flag high.
// [RULE16] Port B mailbox read with generation forces its error flag high.
// [RULE17] Parity generate high makes byte top bits generated parity on reads.
// [RULE18] Writes store all nine bits of every byte as driven.
// [RULE19] Generated bit derives from lower eight bits and odd/even sense.
// [RULE20] FIFO parity made before output load; selects sampled at fetch.
// [RULE21] Mailbox parity made on the read path; stored contents unchanged.
// [RULE22] Both size selects low select long-word size.
// [RULE23] Size and endian inputs registered each edge, applied next edge. The code holds both while both size selects are high.
// [RULE24] Word/byte lane and order placement for big and little endian.
// [RULE25] Word size is hi/lo = LH, byte size is HL.
`timescale 1ns/1ps
`default_nettype none

module frp_read_path
    import frp_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [35:0]       fifo_data_i,
    input  wire logic              fifo_valid_i,
    output logic                   fifo_pop_o,
    input  wire logic [35:0]       a_data_i,
    input  wire logic              a_select_n_i,
    input  wire logic              a_enable_i,
    input  wire logic              a_write_not_read_i,
    input  wire logic              a_mailbox_sel_i,
    input  wire logic              a_parity_generate_i,
    output logic      [35:0]       a_data_o,
    output logic                   a_data_oe_o,
    output logic                   a_parity_error_n_o,
    input  wire logic [35:0]       b_data_i,
    input  wire logic              b_select_n_i,
    input  wire logic              b_enable_i,
    input  wire logic              b_write_not_read_i,
    input  wire logic              b_size_sel_lo_i,
    input  wire logic              b_size_sel_hi_i,
    input  wire logic              big_endian_sel_i,
    input  wire logic              swap_sel_lo_i,
    input  wire logic              swap_sel_hi_i,
    input  wire logic              b_parity_generate_i,
    output logic      [35:0]       b_data_o,
    output logic                   b_data_oe_o,
    output logic                   b_parity_error_n_o
);

    // Per-byte failure flags under the chosen sense
    function automatic logic [3:0] frp_bad(input logic [35:0] d, input logic odd);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 4; i++) begin
            r[i] = ((^(~d[i*FRP_BW +: FRP_BW])) == odd);
        end
        return r;
    endfunction : frp_bad

    // Replace each byte's top bit with parity of its lower eight
    function automatic logic [35:0] frp_gen(input logic [35:0] d, input logic odd);
        logic [35:0] r;
        r = d;
        for (int i = 0; i < 4; i++) begin
            r[i*FRP_BW + 8] = odd ^ (^d[i*FRP_BW +: 8]);
        end
        return r;
    endfunction : frp_gen

    // Byte reorder on whole 9-bit bytes, bits inside unchanged
    function automatic logic [35:0] frp_swap(input logic [35:0] d, input logic [1:0] sw);
        logic [8:0] a;
        logic [8:0] b;
        logic [8:0] c;
        logic [8:0] e;
        logic [35:0] r;
        a = d[35:27];
        b = d[26:18];
        c = d[17:9];
        e = d[8:0];
        unique case (sw)
            2'h0: r = {a, b, c, e};
            2'h1: r = {e, c, b, a};
            2'h2: r = {c, e, a, b};
            2'h3: r = {b, a, e, c};
        endcase
        return r;
    endfunction : frp_swap

    // Lanes valid for a size and endian choice
    function automatic logic [3:0] frp_lanes(input logic [1:0] sz, input logic be);
        logic [3:0] r;
        unique case (sz)
            FRP_SZ_WORD: r = be ? 4'hC : 4'h3;
            FRP_SZ_BYTE: r = be ? 4'h8 : 4'h1;
            default:     r = 4'hF;
        endcase
        return r;
    endfunction : frp_lanes

    logic        odd_sel_q, odd_sel_d;
    logic [1:0]  size_q, size_d;
    logic        be_q, be_d;
    logic [35:0] aux_q, aux_d;
    logic [1:0]  idx_q, idx_d;
    logic        pend_q, pend_d;
    logic [1:0]  last_sz_q, last_sz_d;
    logic [1:0]  sw_q, sw_d;
    logic [35:0] out_q, out_d;
    logic [35:0] mail_ab_q, mail_ab_d;
    logic [35:0] mail_ba_q, mail_ba_d;
    logic [35:0] a_dat_q, a_dat_d;
    logic        a_oe_q, a_oe_d;
    logic        a_pe_q, a_pe_d;
    logic [35:0] b_dat_q, b_dat_d;
    logic        b_oe_q, b_oe_d;
    logic        b_pe_q, b_pe_d;
    logic        pop_d;
    logic [31:0] wb_dat_q, wb_dat_d;
    logic        wb_ack_q, wb_ack_d;

    logic        a_acc, b_acc, b_mail, b_fifo_rd;
    logic [1:0]  nparts;
    logic [35:0] word;
    logic [17:0] half;
    logic [8:0]  onebyte;
    logic        fetch;

    always_comb begin
        a_acc     = !a_select_n_i && a_enable_i;
        b_acc     = !b_select_n_i && b_enable_i;
        b_mail    = b_size_sel_lo_i && b_size_sel_hi_i;
        b_fifo_rd = b_acc && !b_write_not_read_i && !b_mail;
    end

    // Size and endian capture
    always_comb begin
        size_d = size_q;
        be_d   = be_q;
        // [RULE23] register every edge without both size selects high
        // [RULE10] hold size on mailbox
        if (!b_mail) begin
            size_d = {b_size_sel_hi_i, b_size_sel_lo_i};
            be_d   = big_endian_sel_i;
        end
    end

    // Unpacking path
    always_comb begin
        aux_d     = aux_q;
        idx_d     = idx_q;
        pend_d    = pend_q;
        last_sz_d = last_sz_q;
        sw_d      = sw_q;
        out_d     = out_q;
        pop_d     = 1'b0;
        half      = 18'h00000;
        onebyte   = 9'h000;
        word      = aux_q;
        // [RULE25] word LH, byte HL
        // [RULE22] long when both low
        unique case (size_q)
            FRP_SZ_WORD: nparts = 2'h1;
            FRP_SZ_BYTE: nparts = 2'h3;
            default:     nparts = 2'h0;
        endcase
        // [RULE3] size change refetches
        // [RULE1] long always refetches
        fetch = !pend_q || (size_q != last_sz_q) || (nparts == 2'h0);
        if (b_fifo_rd && (!fetch || fifo_valid_i)) begin
            // [RULE11] registered size applied
            if (fetch) begin
                pop_d     = 1'b1;
                last_sz_d = size_q;
                // [RULE6] swap sampled on fetch
                sw_d      = {swap_sel_hi_i, swap_sel_lo_i};
                // [RULE8] swap then split
                // [RULE7] swap codes
                word      = frp_swap(fifo_data_i, {swap_sel_hi_i, swap_sel_lo_i});
                // [RULE20] parity before output load
                if (b_parity_generate_i) begin
                    word = frp_gen(word, odd_sel_q);
                end
                aux_d  = word;
                idx_d  = 2'h0;
                pend_d = (nparts != 2'h0);
            end
            // [RULE24] lane and order placement
            if (be_q) begin
                half    = idx_d[0] ? word[17:0] : word[35:18];
                onebyte = word[35 - 9*idx_d -: 9];
            end else begin
                half    = idx_d[0] ? word[35:18] : word[17:0];
                onebyte = word[9*idx_d +: 9];
            end
            // [RULE4] unused lanes hold
            unique case (size_q)
                FRP_SZ_WORD: begin
                    if (be_q) out_d[35:18] = half;
                    else      out_d[17:0]  = half;
                end
                FRP_SZ_BYTE: begin
                    if (be_q) out_d[35:27] = onebyte;
                    else      out_d[8:0]   = onebyte;
                end
                default: out_d = word;
            endcase
            // [RULE2] remaining parts kept in auxiliary register
            if (idx_d == nparts) begin
                pend_d = 1'b0;
            end
            idx_d = idx_d + 2'h1;
        end
    end

    // Mailboxes and port outputs
    always_comb begin
        mail_ab_d = mail_ab_q;
        mail_ba_d = mail_ba_q;
        // [RULE18] stored exactly as driven
        if (a_acc && a_write_not_read_i && a_mailbox_sel_i) begin
            mail_ab_d = a_data_i;
        end
        // [RULE9] B write loads B-to-A
        if (b_acc && b_write_not_read_i && b_mail) begin
            mail_ba_d = b_data_i;
        end
        a_oe_d  = !a_select_n_i && !a_write_not_read_i;
        a_dat_d = a_dat_q;
        a_pe_d  = !(|frp_bad(a_data_i, odd_sel_q));
        if (a_acc && !a_write_not_read_i && a_mailbox_sel_i) begin
            // [RULE21] generated on read path only
            a_dat_d = a_parity_generate_i ? frp_gen(mail_ba_q, odd_sel_q) : mail_ba_q;
        end
        // [RULE12] all four A bytes checked
        // [RULE15] forced high on A mailbox generate
        if (a_acc && !a_write_not_read_i && a_mailbox_sel_i && a_parity_generate_i) begin
            a_pe_d = 1'b1;
        end
        b_oe_d = !b_select_n_i && !b_write_not_read_i;
        // [RULE5] mailbox data never swapped
        // [RULE9] B read gives A-to-B
        // [RULE17] generate on reads
        if (b_acc && !b_write_not_read_i && b_mail) begin
            b_dat_d = b_parity_generate_i ? frp_gen(mail_ab_q, odd_sel_q) : mail_ab_q;
        end else begin
            b_dat_d = out_d;
        end
        // [RULE13] only valid B lanes
        // [RULE14] odd/even sense
        b_pe_d = !(|(frp_bad(b_data_i, odd_sel_q) & frp_lanes(size_q, be_q)));
        // [RULE16] forced high on B mailbox generate
        if (b_acc && !b_write_not_read_i && b_mail && b_parity_generate_i) begin
            b_pe_d = 1'b1;
        end
    end

    // Wishbone slave, one wait state so reads see settled state
    always_comb begin
        wb_ack_d  = wb_cyc_i && wb_stb_i && !wb_ack_q;
        wb_dat_d  = 32'h00000000;
        odd_sel_d = odd_sel_q;
        if (wb_ack_d) begin
            unique case (wb_adr_i)
                FRP_CTRL_ADR: begin
                    wb_dat_d[FRP_CTRL_ODD] = odd_sel_q;
                end
                FRP_STAT_ADR: begin
                    wb_dat_d[FRP_ST_PEA]         = a_pe_q;
                    wb_dat_d[FRP_ST_PEB]         = b_pe_q;
                    wb_dat_d[FRP_ST_SIZE +: 2]   = size_q;
                    wb_dat_d[FRP_ST_BE]          = be_q;
                    wb_dat_d[FRP_ST_PEND]        = pend_q;
                    wb_dat_d[FRP_ST_IDX +: 2]    = idx_q;
                    wb_dat_d[FRP_ST_SWAP +: 2]   = sw_q;
                end
                default: wb_dat_d = 32'h00000000;
            endcase
        end
        // Write lands on the edge where the master sees ack, not one earlier
        if (wb_ack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
            && (wb_adr_i == FRP_CTRL_ADR)) begin
            odd_sel_d = wb_dat_i[FRP_CTRL_ODD];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odd_sel_q  <= FRP_CTRL_RST;
            size_q     <= FRP_SZ_RST;
            be_q       <= FRP_BE_RST;
            aux_q      <= 36'h000000000;
            idx_q      <= 2'h0;
            pend_q     <= 1'b0;
            last_sz_q  <= FRP_SZ_RST;
            sw_q       <= 2'h0;
            out_q      <= 36'h000000000;
            mail_ab_q  <= 36'h000000000;
            mail_ba_q  <= 36'h000000000;
            a_dat_q    <= 36'h000000000;
            a_oe_q     <= 1'b0;
            a_pe_q     <= 1'b1;
            b_dat_q    <= 36'h000000000;
            b_oe_q     <= 1'b0;
            b_pe_q     <= 1'b1;
            wb_dat_q   <= 32'h00000000;
            wb_ack_q   <= 1'b0;
        end else begin
            odd_sel_q  <= odd_sel_d;
            size_q     <= size_d;
            be_q       <= be_d;
            aux_q      <= aux_d;
            idx_q      <= idx_d;
            pend_q     <= pend_d;
            last_sz_q  <= last_sz_d;
            sw_q       <= sw_d;
            out_q      <= out_d;
            mail_ab_q  <= mail_ab_d;
            mail_ba_q  <= mail_ba_d;
            a_dat_q    <= a_dat_d;
            a_oe_q     <= a_oe_d;
            a_pe_q     <= a_pe_d;
            b_dat_q    <= b_dat_d;
            b_oe_q     <= b_oe_d;
            b_pe_q     <= b_pe_d;
            wb_dat_q   <= wb_dat_d;
            wb_ack_q   <= wb_ack_d;
        end
    end

    // Pop must reach the array in the fetching cycle, so it stays combinational
    assign fifo_pop_o         = pop_d;
    assign wb_dat_o           = wb_dat_q;
    assign wb_ack_o           = wb_ack_q;
    assign a_data_o           = a_dat_q;
    assign a_data_oe_o        = a_oe_q;
    assign a_parity_error_n_o = a_pe_q;
    assign b_data_o           = b_dat_q;
    assign b_data_oe_o        = b_oe_q;
    assign b_parity_error_n_o = b_pe_q;

endmodule : frp_read_path

`default_nettype wire

// ---- dv/frp_fifo_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module frp_fifo_model (
    input  wire logic        clk_i,
    input  wire logic        pop_i,
    output logic      [35:0] data_o,
    output logic             valid_o
);
    logic [35:0] q[$];
    logic [35:0] last_q;
    initial begin
        last_q  = 36'h0;
        valid_o = 1'h0;
        data_o  = 36'hF_FFFF_FFFF;
    end
    task automatic push(input logic [35:0] w);
        q.push_back(w);
        valid_o = 1'h1;
        data_o  = q[0];
    endtask : push
    // Empty head shows the inverted last word, so a stale read cannot pass
    always @(posedge clk_i) begin
        if (pop_i && q.size() != 0) begin
            last_q = q.pop_front();
            valid_o <= (q.size() != 0);
            data_o  <= (q.size() != 0) ? q[0] : ~last_q;
        end
    end
endmodule : frp_fifo_model
`default_nettype wire

// ---- dv/frp_read_path_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module frp_read_path_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [35:0] fifo_data_i,
    input wire logic        fifo_valid_i,
    input wire logic        fifo_pop_o,
    input wire logic [35:0] a_data_i,
    input wire logic        a_select_n_i,
    input wire logic        a_enable_i,
    input wire logic        a_write_not_read_i,
    input wire logic        a_mailbox_sel_i,
    input wire logic        a_parity_generate_i,
    input wire logic [35:0] a_data_o,
    input wire logic        a_parity_error_n_o,
    input wire logic [35:0] b_data_i,
    input wire logic        b_select_n_i,
    input wire logic        b_enable_i,
    input wire logic        b_write_not_read_i,
    input wire logic        b_size_sel_lo_i,
    input wire logic        b_size_sel_hi_i,
    input wire logic        swap_sel_lo_i,
    input wire logic        swap_sel_hi_i,
    input wire logic        b_parity_generate_i,
    input wire logic [35:0] b_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic        a_rd, b_on, b_rd, b_mb, b_lg;
    logic [1:0]  sw;
    logic [35:0] a2b_q, b2a_q;
    assign a_rd = !a_select_n_i && a_enable_i && !a_write_not_read_i && a_mailbox_sel_i;
    assign b_on = !b_select_n_i && b_enable_i;
    assign b_rd = b_on && !b_write_not_read_i;
    assign b_mb = b_size_sel_hi_i && b_size_sel_lo_i;
    assign b_lg = !b_size_sel_hi_i && !b_size_sel_lo_i;
    assign sw   = {swap_sel_hi_i, swap_sel_lo_i};
    // Shadow mailboxes follow the writes seen at the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a2b_q <= 36'h0;
            b2a_q <= 36'h0;
        end else begin
            if (!a_select_n_i && a_enable_i && a_write_not_read_i && a_mailbox_sel_i)
                a2b_q <= a_data_i;
            if (b_on && b_write_not_read_i && b_mb)
                b2a_q <= b_data_i;
        end
    end
    function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] s);
        case (s)
            2'h1:    swp = {w[8:0], w[17:9], w[26:18], w[35:27]};
            2'h2:    swp = {w[17:0], w[35:18]};
            2'h3:    swp = {w[26:18], w[35:27], w[8:0], w[17:9]};
            default: swp = w;
        endcase
    endfunction : swp
    sequence s_long_rd;
        $past(b_lg) && b_rd && !b_mb;
    endsequence
    sequence s_fetch;
        s_long_rd ##0 (fifo_pop_o && !b_parity_generate_i);
    endsequence
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    chk_pop_has_word: assert property (fifo_pop_o |-> fifo_valid_i)
        else $error("pop while array empty");
    chk_long_pops: assert property (s_long_rd ##0 fifo_valid_i |-> fifo_pop_o)
        else $error("long read without pop");
    chk_long_swap: assert property (s_fetch |=> b_data_o == swp($past(fifo_data_i), $past(sw)))
        else $error("long read data wrong");
    chk_mail_nopop: assert property (b_on && b_mb |-> !fifo_pop_o)
        else $error("mailbox access popped array");
    chk_mail_b_rd: assert property (b_rd && b_mb && !b_parity_generate_i |=> b_data_o == $past(a2b_q))
        else $error("port B mailbox read wrong");
    chk_mail_a_rd: assert property (a_rd && !a_parity_generate_i |=> a_data_o == $past(b2a_q))
        else $error("port A mailbox read wrong");
    chk_force_a: assert property (a_rd && a_parity_generate_i |=> a_parity_error_n_o)
        else $error("port A flag not forced");
    chk_b_hold: assert property (!$past(rst_i) && !$past(rst_i, 2) && !$past(b_on) && !$past(b_on, 2) |-> $stable(b_data_o))
        else $error("port B output moved without access");
endmodule : frp_read_path_chk
`default_nettype wire

// ---- dv/tb_frp_read_path.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_frp_read_path;
    import frp_pkg::*;
    logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, pop, vld;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rv;
    logic [35:0] fdat, ad = 36'h0, ado, bd = 36'h0, bdo;
    logic        as_n = 1'h1, awr = 1'h0, amb = 1'h0, apg = 1'h0, aoe, ape_n;
    logic        bs_n = 1'h1, bwr = 1'h0, slo = 1'h0, shi = 1'h0, bbe = 1'h0;
    logic        swl = 1'h0, swh = 1'h0, bpg = 1'h0, boe, bpe_n;
    logic        aen = 1'h1, ben = 1'h1;
    logic [3:0]  sel = 4'h0;
    int          fail_count = 0, n_compared = 0;
    always #20 clk_i = ~clk_i;
    frp_read_path uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .fifo_data_i(fdat), .fifo_valid_i(vld), .fifo_pop_o(pop),
        .a_data_i(ad), .a_select_n_i(as_n), .a_enable_i(aen), .a_write_not_read_i(awr),
        .a_mailbox_sel_i(amb), .a_parity_generate_i(apg), .a_data_o(ado), .a_data_oe_o(aoe),
        .a_parity_error_n_o(ape_n), .b_data_i(bd), .b_select_n_i(bs_n), .b_enable_i(ben),
        .b_write_not_read_i(bwr), .b_size_sel_lo_i(slo), .b_size_sel_hi_i(shi),
        .big_endian_sel_i(bbe), .swap_sel_lo_i(swl), .swap_sel_hi_i(swh),
        .b_parity_generate_i(bpg), .b_data_o(bdo), .b_data_oe_o(boe), .b_parity_error_n_o(bpe_n));
    frp_fifo_model u_fifo (.clk_i(clk_i), .pop_i(pop), .data_o(fdat), .valid_o(vld));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : cmp
    function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] s);
        case (s)
            2'h1:    swp = {w[8:0], w[17:9], w[26:18], w[35:27]};
            2'h2:    swp = {w[17:0], w[35:18]};
            2'h3:    swp = {w[26:18], w[35:27], w[8:0], w[17:9]};
            default: swp = w;
        endcase
    endfunction : swp
    function automatic logic [35:0] gp(input logic [35:0] w, input logic o);
        for (int i = 0; i < 4; i++) w[9*i+8] = o ^ (^w[9*i +: 8]);
        return w;
    endfunction : gp
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, wdat} <= {2'h3, w, 4'hF, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 16);
        rv = rdat;
        {cyc, stb} <= 2'h0;
        if (n >= 16) begin
            fail_count++;
            print_verdict();
        end
    endtask : wb
    // Size goes up one edge ahead of the select, except for mailbox access
    task automatic b_op(input logic [1:0] sz, input logic be, input logic [1:0] s,
                        input logic g, input logic w, input logic [35:0] d);
        @(posedge clk_i);
        {shi, slo, bbe, swh, swl, bpg} <= {sz, be, s, g};
        if (sz != FRP_SZ_MAIL) @(posedge clk_i);
        {bs_n, bwr, bd} <= {1'h0, w, d};
        @(posedge clk_i);
        bs_n <= 1'h1;
        @(negedge clk_i);
    endtask : b_op
    task automatic a_op(input logic w, input logic g, input logic [35:0] d);
        @(posedge clk_i);
        {as_n, amb, awr, apg, ad} <= {2'h1, w, g, d};
        @(posedge clk_i);
        {as_n, apg} <= 2'h2;
        @(negedge clk_i);
    endtask : a_op
    task automatic t_regs();
        wb(1'h0, FRP_CTRL_ADR, 32'h0);
        cmp(36'(rv[FRP_CTRL_ODD]), 36'(FRP_CTRL_RST));
        wb(1'h1, 8'h10, 32'hFFFFFFFF);
        wb(1'h0, 8'h10, 32'h0);
        cmp(36'(rv), 36'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_long();
        logic [35:0] e;
        for (int s = 0; s < 4; s++) begin
            u_fifo.push(36'hF_EDCB_A987 + 36'(s));
            b_op(FRP_SZ_LONG, 1'h0, 2'(s), 1'(s / 3), 1'h0, 36'h0);
            e = swp(36'hF_EDCB_A987 + 36'(s), 2'(s));
            if (s == 3) e = gp(e, 1'h1);
            cmp(bdo, e);
            cmp(36'(boe), 36'h1);
        end
        cmp(36'(vld), 36'h0);
        $display("test long done");
    endtask : t_long
    task automatic t_word();
        logic [35:0] s, m;
        logic [17:0] lo;
        s = swp(36'h1_2345_6789, 2'h1);
        m = 36'h1;
        lo = bdo[17:0];
        a_op(1'h1, 1'h0, m);
        // Write with enable low must leave the mailbox alone
        @(posedge clk_i) aen <= 1'h0;
        a_op(1'h1, 1'h0, 36'h5);
        @(posedge clk_i) aen <= 1'h1;
        u_fifo.push(36'h1_2345_6789);
        b_op(FRP_SZ_WORD, 1'h1, 2'h1, 1'h0, 1'h0, 36'h0);
        cmp(bdo, {s[35:18], lo});
        wb(1'h0, FRP_STAT_ADR, 32'h0);
        cmp(36'(rv[FRP_ST_SIZE +: 8]), 36'h5D);
        b_op(FRP_SZ_MAIL, 1'h0, 2'h2, 1'h1, 1'h0, 36'h0);
        cmp(bdo, gp(m, 1'h1));
        cmp(36'(bpe_n), 36'h1);
        b_op(FRP_SZ_MAIL, 1'h0, 2'h2, 1'h0, 1'h0, 36'h0);
        cmp(bdo, m);
        b_op(FRP_SZ_WORD, 1'h1, 2'h3, 1'h0, 1'h0, 36'h0);
        cmp(bdo, {s[17:0], lo});
        cmp(36'(vld), 36'h0);
        $display("test word done");
    endtask : t_word
    task automatic t_byte();
        logic [35:0] s;
        logic [26:0] hi;
        s = swp(36'hA_B0C0_D0E1, 2'h2);
        hi = bdo[35:9];
        u_fifo.push(36'hA_B0C0_D0E1);
        u_fifo.push(36'h5_5AA5_F00F);
        b_op(FRP_SZ_BYTE, 1'h0, 2'h2, 1'h0, 1'h0, 36'h100);
        cmp(bdo, {hi, s[8:0]});
        cmp(36'(bpe_n), 36'h1);
        b_op(FRP_SZ_BYTE, 1'h0, 2'h0, 1'h0, 1'h0, 36'h0);
        cmp(bdo, {hi, s[17:9]});
        b_op(FRP_SZ_LONG, 1'h0, 2'h0, 1'h0, 1'h0, 36'h100);
        cmp(bdo, 36'h5_5AA5_F00F);
        cmp(36'(bpe_n), 36'h0);
        $display("test byte done");
    endtask : t_byte
    task automatic t_mail_a();
        b_op(FRP_SZ_MAIL, 1'h0, 2'h0, 1'h0, 1'h1, 36'h3);
        a_op(1'h0, 1'h1, 36'h0);
        cmp(ado, gp(36'h3, 1'h1));
        cmp(36'(aoe), 36'h1);
        cmp(36'(ape_n), 36'h1);
        a_op(1'h0, 1'h0, 36'h0);
        cmp(ado, 36'h3);
        cmp(36'(ape_n), 36'h0);
        @(posedge clk_i) ad <= gp(36'h0, 1'h1);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        cmp(36'(ape_n), 36'h1);
        // Even sense makes every byte of the same word fail
        wb(1'h1, FRP_CTRL_ADR, 32'h0);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        cmp(36'(ape_n), 36'h0);
        wb(1'h1, FRP_CTRL_ADR, 32'h1);
        $display("test mail_a done");
    endtask : t_mail_a
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_long();
        t_word();
        t_byte();
        t_mail_a();
        print_verdict();
    end
endmodule : tb_frp_read_path
bind frp_read_path frp_read_path_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fifo_data_i(fifo_data_i),
    .fifo_valid_i(fifo_valid_i), .fifo_pop_o(fifo_pop_o), .a_data_i(a_data_i),
    .a_select_n_i(a_select_n_i), .a_enable_i(a_enable_i), .a_write_not_read_i(a_write_not_read_i),
    .a_mailbox_sel_i(a_mailbox_sel_i), .a_parity_generate_i(a_parity_generate_i),
    .a_data_o(a_data_o), .a_parity_error_n_o(a_parity_error_n_o), .b_data_i(b_data_i),
    .b_select_n_i(b_select_n_i), .b_enable_i(b_enable_i), .b_write_not_read_i(b_write_not_read_i),
    .b_size_sel_lo_i(b_size_sel_lo_i), .b_size_sel_hi_i(b_size_sel_hi_i),
    .swap_sel_lo_i(swap_sel_lo_i), .swap_sel_hi_i(swap_sel_hi_i),
    .b_parity_generate_i(b_parity_generate_i), .b_data_o(b_data_o));
`default_nettype wire
